// [lowv_pkg.sv]
// Shared constants, register map and types of the low-voltage detect control block
package lowv_pkg;

    // ==========================================================
    // Register bus
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_PMC_ONE = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_PMC_TWO = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_RST_SRC = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 3'h4;

    // ==========================================================
    // Field positions, power_mgmt_ctrl_one
    localparam int P1_ENABLE = 0;
    localparam int P1_STOP_ENABLE = 1;
    localparam int P1_RESET_ENABLE = 2;
    localparam int P1_IRQ_ENABLE = 3;
    localparam int P1_DETECT_FLAG = 4;
    localparam int P1_DETECT_ACK = 5;

    // Field positions, power_mgmt_ctrl_two
    localparam int P2_DETECT_LEVEL = 0;
    localparam int P2_WARNING_LEVEL = 1;
    localparam int P2_WARNING_FLAG = 4;

    // Field positions, reset_source_status
    localparam int RS_LOWV = 0;
    localparam int RS_POR = 1;

    // Event status and mask bits
    localparam int EVT_W = 2;
    localparam int EVT_STOP_REFUSED = 0;
    localparam int EVT_DETECTOR_OFF = 1;

    // ==========================================================
    // Values after reset
    localparam logic [3:0] PMC_ONE_RESET = 4'h5;
    localparam logic [1:0] PMC_TWO_RESET = 2'h0;
    localparam logic [1:0] RST_SRC_POR_VALUE = 2'h3;
    localparam logic [1:0] RST_SRC_LOWV_VALUE = 2'h1;
    localparam logic [EVT_W-1:0] EVT_MASK_RESET = 2'h0;
    // Trips read as "supply low" until the synchroniser has seen real levels
    localparam logic [3:0] TRIP_SYNC_RESET = 4'hf;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        STOP_NONE = 2'h0,
        STOP_DEEPEST = 2'h1,
        STOP_MIDDLE = 2'h2,
        STOP_SHALLOW = 2'h3
    } stop_mode_t;

    typedef enum logic [3:0] {
        ST_POR_HOLD = 4'h1,
        ST_RUN = 4'h2,
        ST_LOWV_HOLD = 4'h4,
        ST_STOP = 4'h8
    } seq_state_t;

endpackage

// [lowv_evt_if.sv]
// Carrier between the sequencer and its sticky event/mask unit
`timescale 1ns/100ps
interface lowv_evt_if #(
    parameter int EVT_W = lowv_pkg::EVT_W
);
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] clr;
    logic mask_we;
    logic [EVT_W-1:0] mask_wdata;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;

    modport ctrl (output evt, output clr, output mask_we, output mask_wdata, input status, input mask);
    modport unit (input evt, input clr, input mask_we, input mask_wdata, output status, output mask);
endinterface

// [sync_bits.sv]
// Two-flop synchroniser, one chain per bit
`timescale 1ns/100ps
module sync_bits #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_q;
        logic sync_q;
        // First stage feeds only the second stage
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                meta_q <= RESET_VAL[i];
                sync_q <= RESET_VAL[i];
            end else begin
                meta_q <= d_in[i];
                sync_q <= meta_q;
            end
        end
        assign q_out[i] = sync_q;
    end
endmodule // sync_bits

// [event_irq.sv]
// Sticky event status with write-one-to-clear and a mask register
`timescale 1ns/100ps
module event_irq
    import lowv_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    lowv_evt_if.unit evt_if
);
    logic [EVT_W-1:0] status_q;
    logic [EVT_W-1:0] mask_q;

    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~evt_if.clr) | evt_if.evt;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_q <= EVT_MASK_RESET;
        end else if (evt_if.mask_we) begin
            mask_q <= evt_if.mask_wdata;
        end
    end

    assign evt_if.status = status_q;
    assign evt_if.mask = mask_q;
endmodule // event_irq

// [low_voltage_detect_control.sv]
// Low-voltage detect control: reset hold, detect/warning flags, stop-mode gating, registers
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps

// Overview of operation
// - Detector runs only while lowv_enable is set.
// - detect_level_select picks high or low detect trip.
// - Stop entry turns the detector off unless lowv_stop_enable is set.
// - Enable plus stop enable refuses deepest and middle stop; shallow allowed.
// - After power-on, reset holds until low trip shows supply above low level.
// - Power-on sets both power-on and low-voltage reset-source bits.
// - With reset enable, a low condition resets until supply clears selected level.
// - Detector-caused reset sets the low-voltage reset-source bit.
// - Enable, irq enable, no reset enable: low condition sets detect flag.
// - Warning flag shows supply nearing detect level; never interrupts.
// - warning_level_select picks high or low warning trip.
// - Detector request forwarded only when flag set and irq enable is one.
module low_voltage_detect_control (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [lowv_pkg::ADDR_W-1:0] addr_in,
    input wire logic [lowv_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [lowv_pkg::DATA_W-1:0] rdata_out,
    input wire logic detect_high_trip_in,
    input wire logic detect_low_trip_in,
    input wire logic warn_high_trip_in,
    input wire logic warn_low_trip_in,
    input wire logic stop_req_in,
    input wire lowv_pkg::stop_mode_t stop_mode_in,
    input wire logic wake_in,
    output logic stop_grant_out,
    output lowv_pkg::stop_mode_t stop_mode_out,
    output logic in_stop_out,
    output logic detector_on_out,
    output logic detect_level_out,
    output logic warning_level_out,
    output logic sys_reset_out,
    output logic irq_out
);
    import lowv_pkg::*;

    // ==========================================================
    // Trip synchronisers
    logic [3:0] trips_raw;
    logic [3:0] trips_s;
    logic detect_high_s;
    logic detect_low_s;
    logic warn_high_s;
    logic warn_low_s;

    assign trips_raw = {warn_low_trip_in, warn_high_trip_in, detect_low_trip_in, detect_high_trip_in};

    // Comparators are analog and asynchronous to the bus clock
    sync_bits #(
        .WIDTH(4),
        .RESET_VAL(TRIP_SYNC_RESET)
    ) u_trip_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .d_in(trips_raw),
        .q_out(trips_s)
    );

    assign detect_high_s = trips_s[0];
    assign detect_low_s = trips_s[1];
    assign warn_high_s = trips_s[2];
    assign warn_low_s = trips_s[3];

    // ==========================================================
    // Registers and state
    seq_state_t state_q;
    seq_state_t state_d;
    logic lowv_enable_q;
    logic lowv_stop_enable_q;
    logic lowv_reset_enable_q;
    logic lowv_irq_enable_q;
    logic lowv_detect_flag_q;
    logic detect_level_select_q;
    logic warning_level_select_q;
    logic lowv_warning_flag_q;
    logic [1:0] reset_source_status_q;
    logic detector_on_q;
    logic sys_reset_q;
    logic stop_grant_q;
    stop_mode_t stop_mode_q;
    logic in_stop_q;
    logic irq_q;
    logic [DATA_W-1:0] rdata_q;

    // ==========================================================
    // Register decode
    logic wr_pmc_one;
    logic wr_pmc_two;
    logic wr_evt_status;
    logic wr_evt_mask;

    assign wr_pmc_one = wr_in && (addr_in == ADDR_PMC_ONE);
    assign wr_pmc_two = wr_in && (addr_in == ADDR_PMC_TWO);
    assign wr_evt_status = wr_in && (addr_in == ADDR_EVT_STATUS);
    assign wr_evt_mask = wr_in && (addr_in == ADDR_EVT_MASK);

    // ==========================================================
    // Event unit
    lowv_evt_if #(.EVT_W(EVT_W)) evt_bus ();

    event_irq u_event_irq (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .evt_if(evt_bus)
    );

    // ==========================================================
    // Detection terms
    logic detect_trip;
    logic warn_trip;
    logic lowv_cond;
    logic lowv_reset_hit;
    logic deep_req;
    logic stop_valid_req;
    logic stop_blocked;
    logic stop_ok;
    logic detect_set;
    logic detect_clr;
    logic detector_on_d;

    assign detect_trip = detect_level_select_q ? detect_high_s : detect_low_s;
    assign warn_trip = warning_level_select_q ? warn_high_s : warn_low_s;

    // Comparator output counts only while the detector is powered
    assign lowv_cond = detector_on_q && detect_trip;
    assign lowv_reset_hit = lowv_cond && lowv_reset_enable_q;

    assign deep_req = (stop_mode_in == STOP_DEEPEST) || (stop_mode_in == STOP_MIDDLE);
    assign stop_valid_req = stop_req_in && (stop_mode_in != STOP_NONE) && (state_q == ST_RUN);
    // Deep stops would cut the detector's supply, so they are refused
    assign stop_blocked = lowv_enable_q && lowv_stop_enable_q && deep_req;
    // A pending low-voltage reset outranks the stop request
    assign stop_ok = stop_valid_req && !stop_blocked && !lowv_reset_hit;

    assign detect_set = lowv_cond && lowv_enable_q && lowv_irq_enable_q && !lowv_reset_enable_q;
    assign detect_clr = wr_pmc_one && wdata_in[P1_DETECT_ACK];

    assign evt_bus.evt[EVT_STOP_REFUSED] = stop_valid_req && stop_blocked;
    assign evt_bus.evt[EVT_DETECTOR_OFF] = stop_ok && lowv_enable_q && !lowv_stop_enable_q;
    assign evt_bus.clr = wr_evt_status ? wdata_in[EVT_W-1:0] : '0;
    assign evt_bus.mask_we = wr_evt_mask;
    assign evt_bus.mask_wdata = wdata_in[EVT_W-1:0];

    // ==========================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_POR_HOLD: begin
                // Released only once the supply is above the low level
                if (!detect_low_s) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (lowv_reset_hit) begin
                    state_d = ST_LOWV_HOLD;
                end else if (stop_ok) begin
                    state_d = ST_STOP;
                end
            end
            ST_LOWV_HOLD: begin
                if (!detect_trip) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (lowv_reset_hit) begin
                    state_d = ST_LOWV_HOLD;
                end else if (wake_in) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_POR_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= ST_POR_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sys_reset_q <= 1'b1;
        end else begin
            sys_reset_q <= (state_d == ST_POR_HOLD) || (state_d == ST_LOWV_HOLD);
        end
    end

    // ==========================================================
    // Detector power; kept on through a detector-held reset
    assign detector_on_d = lowv_enable_q && ((state_d != ST_STOP) || lowv_stop_enable_q);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            detector_on_q <= PMC_ONE_RESET[P1_ENABLE];
        end else begin
            detector_on_q <= detector_on_d;
        end
    end

    // ==========================================================
    // Stop handshake
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stop_grant_q <= 1'b0;
            stop_mode_q <= STOP_NONE;
            in_stop_q <= 1'b0;
        end else begin
            stop_grant_q <= stop_ok;
            in_stop_q <= (state_d == ST_STOP);
            if (stop_ok) begin
                stop_mode_q <= stop_mode_in;
            end else if (state_d != ST_STOP) begin
                stop_mode_q <= STOP_NONE;
            end
        end
    end

    // ==========================================================
    // Control registers; they survive a detector-held reset
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lowv_enable_q <= PMC_ONE_RESET[P1_ENABLE];
            lowv_stop_enable_q <= PMC_ONE_RESET[P1_STOP_ENABLE];
            lowv_reset_enable_q <= PMC_ONE_RESET[P1_RESET_ENABLE];
            lowv_irq_enable_q <= PMC_ONE_RESET[P1_IRQ_ENABLE];
        end else if (wr_pmc_one) begin
            lowv_enable_q <= wdata_in[P1_ENABLE];
            lowv_stop_enable_q <= wdata_in[P1_STOP_ENABLE];
            lowv_reset_enable_q <= wdata_in[P1_RESET_ENABLE];
            lowv_irq_enable_q <= wdata_in[P1_IRQ_ENABLE];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            detect_level_select_q <= PMC_TWO_RESET[P2_DETECT_LEVEL];
            warning_level_select_q <= PMC_TWO_RESET[P2_WARNING_LEVEL];
        end else if (wr_pmc_two) begin
            detect_level_select_q <= wdata_in[P2_DETECT_LEVEL];
            warning_level_select_q <= wdata_in[P2_WARNING_LEVEL];
        end
    end

    // ==========================================================
    // Flags
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lowv_detect_flag_q <= 1'b0;
        end else begin
            // Set wins over the acknowledge written in the same cycle
            lowv_detect_flag_q <= detect_set || (lowv_detect_flag_q && !detect_clr);
        end
    end

    // Live status only; deliberately left out of every interrupt term
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lowv_warning_flag_q <= 1'b0;
        end else begin
            lowv_warning_flag_q <= detector_on_q && warn_trip;
        end
    end

    // Reset source: power-on marks both, a detector reset marks only low-voltage
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reset_source_status_q <= RST_SRC_POR_VALUE;
        end else if ((state_d == ST_LOWV_HOLD) && (state_q != ST_LOWV_HOLD)) begin
            reset_source_status_q <= RST_SRC_LOWV_VALUE;
        end
    end

    // ==========================================================
    // Interrupt
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (lowv_detect_flag_q && lowv_irq_enable_q) || (|(evt_bus.status & evt_bus.mask));
        end
    end

    // ==========================================================
    // Read port; data stand only in the cycle after the strobe
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        case (addr_in)
            ADDR_PMC_ONE: begin
                rd_mux[P1_ENABLE] = lowv_enable_q;
                rd_mux[P1_STOP_ENABLE] = lowv_stop_enable_q;
                rd_mux[P1_RESET_ENABLE] = lowv_reset_enable_q;
                rd_mux[P1_IRQ_ENABLE] = lowv_irq_enable_q;
                rd_mux[P1_DETECT_FLAG] = lowv_detect_flag_q;
            end
            ADDR_PMC_TWO: begin
                rd_mux[P2_DETECT_LEVEL] = detect_level_select_q;
                rd_mux[P2_WARNING_LEVEL] = warning_level_select_q;
                rd_mux[P2_WARNING_FLAG] = lowv_warning_flag_q;
            end
            ADDR_RST_SRC: begin
                rd_mux[1:0] = reset_source_status_q;
            end
            ADDR_EVT_STATUS: begin
                rd_mux[EVT_W-1:0] = evt_bus.status;
            end
            ADDR_EVT_MASK: begin
                rd_mux[EVT_W-1:0] = evt_bus.mask;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd_in ? rd_mux : '0;
        end
    end

    // ==========================================================
    // Outputs
    assign rdata_out = rdata_q;
    assign stop_grant_out = stop_grant_q;
    assign stop_mode_out = stop_mode_q;
    assign in_stop_out = in_stop_q;
    assign detector_on_out = detector_on_q;
    assign detect_level_out = detect_level_select_q;
    assign warning_level_out = warning_level_select_q;
    assign sys_reset_out = sys_reset_q;
    assign irq_out = irq_q;

endmodule // low_voltage_detect_control

// [low_voltage_detect_control_monitor.sv]
// Port-level checker of the low-voltage detect control block
`timescale 1ns/100ps
module low_voltage_detect_control_monitor (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [lowv_pkg::ADDR_W-1:0] addr_in,
    input wire logic [lowv_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic detect_high_trip_in,
    input wire logic detect_low_trip_in,
    input wire logic stop_req_in,
    input wire lowv_pkg::stop_mode_t stop_mode_in,
    input wire logic stop_grant_out,
    input wire lowv_pkg::stop_mode_t stop_mode_out,
    input wire logic in_stop_out,
    input wire logic detector_on_out,
    input wire logic sys_reset_out,
    input wire logic irq_out
);
    import lowv_pkg::*;

    // ==========================================================
    // Shadow of the control bits, rebuilt from bus writes
    logic en_q, se_q, re_q, ie_q, lvl_q;
    logic [EVT_W-1:0] mask_q;
    logic clr_wr;
    logic sel_trip;
    logic run;

    assign clr_wr = wr_in && addr_in == ADDR_PMC_ONE && wdata_in[P1_DETECT_ACK];
    assign sel_trip = lvl_q ? detect_high_trip_in : detect_low_trip_in;
    assign run = !in_stop_out && !sys_reset_out;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {ie_q, re_q, se_q, en_q} <= PMC_ONE_RESET;
        end else if (wr_in && addr_in == ADDR_PMC_ONE) begin
            {ie_q, re_q, se_q, en_q} <= wdata_in[3:0];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lvl_q <= PMC_TWO_RESET[P2_DETECT_LEVEL];
        end else if (wr_in && addr_in == ADDR_PMC_TWO) begin
            lvl_q <= wdata_in[P2_DETECT_LEVEL];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_q <= EVT_MASK_RESET;
        end else if (wr_in && addr_in == ADDR_EVT_MASK) begin
            mask_q <= wdata_in[EVT_W-1:0];
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    // Two cycles of margin for the registered power switch
    a_detector_off_disabled: assert property ((!en_q) [*2] |-> !detector_on_out)
        else $error("detector powered while disabled");
    a_stop_detector_off: assert property (in_stop_out && !se_q |-> !detector_on_out)
        else $error("detector left on in stop");
    a_deep_stop_refused: assert property (stop_req_in && run && en_q && se_q
        && stop_mode_in inside {STOP_DEEPEST, STOP_MIDDLE} |-> ##1 !stop_grant_out ##1 !stop_grant_out && !in_stop_out)
        else $error("deep stop granted with detector kept on");
    a_shallow_granted: assert property (stop_req_in && run && stop_mode_in == STOP_SHALLOW
        |-> ##[1:2] (stop_grant_out && stop_mode_out == STOP_SHALLOW))
        else $error("shallow stop not granted");
    a_grant_single_pulse: assert property (stop_grant_out |=> !stop_grant_out && in_stop_out)
        else $error("grant not a single pulse into stop");
    a_reset_release: assert property ($fell(sys_reset_out) |-> !$past(sel_trip, 2) && !$past(sel_trip, 3))
        else $error("reset released while supply low");
    a_lowv_reset: assert property ((en_q && re_q && !in_stop_out && sel_trip) [*6] |-> sys_reset_out)
        else $error("no reset on low supply");
    a_lowv_irq: assert property ((en_q && ie_q && !re_q && !in_stop_out && sel_trip) [*7] |-> irq_out)
        else $error("no interrupt on low supply");
    a_irq_gated: assert property ((!ie_q && mask_q == '0) [*2] |-> !irq_out)
        else $error("interrupt without enable");
    a_irq_held: assert property (irq_out && ie_q && $past(mask_q) == '0 && !$past(clr_wr) |=> irq_out)
        else $error("interrupt dropped while flag set");

    c_stop_grant: cover property (stop_grant_out);
    c_reset_release: cover property ($fell(sys_reset_out));
    c_flag_irq: cover property (irq_out && ie_q);
endmodule // low_voltage_detect_control_monitor

bind low_voltage_detect_control low_voltage_detect_control_monitor low_voltage_detect_control_monitor_inst (
    .clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .detect_high_trip_in, .detect_low_trip_in,
    .stop_req_in, .stop_mode_in, .stop_grant_out, .stop_mode_out, .in_stop_out, .detector_on_out,
    .sys_reset_out, .irq_out
);

// [testbench.sv]
// Self-checking bench of the low-voltage detect control block
`timescale 1ns/100ps
module testbench;
    import lowv_pkg::*;

    // ==========================================================
    // Signals
    logic clk_in = 1'h0;
    logic rstn_in = 1'h0;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wdata_in = '0;
    logic wr_in = 1'h0;
    logic rd_in = 1'h0;
    logic detect_high_trip_in = 1'h1;
    logic detect_low_trip_in = 1'h1;
    logic warn_high_trip_in = 1'h1;
    logic warn_low_trip_in = 1'h1;
    logic stop_req_in = 1'h0;
    stop_mode_t stop_mode_in = STOP_NONE;
    logic wake_in = 1'h0;
    logic [DATA_W-1:0] rdata_out;
    logic stop_grant_out, in_stop_out, detector_on_out, detect_level_out, warning_level_out, sys_reset_out, irq_out;
    stop_mode_t stop_mode_out;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    always #25 clk_in = ~clk_in;

    low_voltage_detect_control low_voltage_detect_control_inst (
        .clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .detect_high_trip_in, .detect_low_trip_in, .warn_high_trip_in, .warn_low_trip_in,
        .stop_req_in, .stop_mode_in, .wake_in, .stop_grant_out, .stop_mode_out, .in_stop_out,
        .detector_on_out, .detect_level_out, .warning_level_out, .sys_reset_out, .irq_out
    );

    // ==========================================================
    // Tasks
    task automatic report_and_stop();
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: read got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'h1;
        @(posedge clk_in);
        wr_in <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge clk_in);
        rd_in <= 1'h0;
        #1;
        chk_byte(rdata_out, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Order: detect high, detect low, warn high, warn low
    task automatic set_trips(input logic [3:0] t);
        @(posedge clk_in);
        {detect_high_trip_in, detect_low_trip_in, warn_high_trip_in, warn_low_trip_in} <= t;
    endtask

    task automatic stop_try(input stop_mode_t m, input logic exp_grant);
        logic seen;
        seen = 1'h0;
        @(posedge clk_in);
        stop_req_in <= 1'h1;
        stop_mode_in <= m;
        @(posedge clk_in);
        stop_req_in <= 1'h0;
        repeat (3) begin
            #1;
            seen = seen | (stop_grant_out === 1'h1);
            @(posedge clk_in);
        end
        #1;
        chk_bit(seen, exp_grant);
    endtask

    task automatic wake_up();
        @(posedge clk_in);
        wake_in <= 1'h1;
        @(posedge clk_in);
        wake_in <= 1'h0;
        settle(2);
    endtask

    // ==========================================================
    // Hang guard, far above the under two hundred cycles needed
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Sequence
    initial begin
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'h1;
        settle(6);
        chk_bit(sys_reset_out, 1'h1);
        chk_bit(detector_on_out, 1'h1);
        reg_check(ADDR_PMC_ONE, 8'h05);
        reg_check(ADDR_RST_SRC, 8'h03);
        reg_write(ADDR_RST_SRC, 8'h00);
        reg_check(ADDR_RST_SRC, 8'h03);
        reg_check(3'h7, 8'h00);
        set_trips(4'h2);
        settle(6);
        chk_bit(sys_reset_out, 1'h0);
        reg_check(ADDR_PMC_TWO, 8'h00);
        reg_write(ADDR_PMC_TWO, 8'h02);
        settle(4);
        chk_bit(warning_level_out, 1'h1);
        reg_check(ADDR_PMC_TWO, 8'h12);
        chk_bit(irq_out, 1'h0);
        // Interrupt path
        reg_write(ADDR_PMC_ONE, 8'h09);
        set_trips(4'hf);
        settle(7);
        chk_bit(irq_out, 1'h1);
        chk_bit(sys_reset_out, 1'h0);
        reg_check(ADDR_PMC_ONE, 8'h19);
        set_trips(4'h0);
        settle(6);
        chk_bit(irq_out, 1'h1);
        reg_write(ADDR_PMC_ONE, 8'h01);
        settle(3);
        chk_bit(irq_out, 1'h0);
        reg_check(ADDR_PMC_ONE, 8'h11);
        reg_write(ADDR_PMC_ONE, 8'h21);
        set_trips(4'hf);
        settle(7);
        chk_bit(irq_out, 1'h0);
        reg_check(ADDR_PMC_ONE, 8'h01);
        // Reset path, supply between the two detect levels
        set_trips(4'hb);
        reg_write(ADDR_PMC_ONE, 8'h05);
        settle(7);
        chk_bit(sys_reset_out, 1'h0);
        reg_write(ADDR_PMC_TWO, 8'h01);
        settle(7);
        chk_bit(detect_level_out, 1'h1);
        chk_bit(sys_reset_out, 1'h1);
        reg_check(ADDR_RST_SRC, 8'h01);
        set_trips(4'h0);
        settle(6);
        chk_bit(sys_reset_out, 1'h0);
        reg_write(ADDR_PMC_ONE, 8'h04);
        set_trips(4'hf);
        settle(7);
        chk_bit(detector_on_out, 1'h0);
        chk_bit(sys_reset_out, 1'h0);
        set_trips(4'h0);
        settle(4);
        // Stop entry with the detector kept on, then switched off
        reg_write(ADDR_EVT_MASK, 8'h03);
        reg_write(ADDR_PMC_ONE, 8'h03);
        for (int m = 1; m <= 2; m++) begin
            stop_try(stop_mode_t'(m), 1'h0);
            chk_bit(in_stop_out, 1'h0);
            reg_check(ADDR_EVT_STATUS, 8'h01);
            chk_bit(irq_out, 1'h1);
            reg_write(ADDR_EVT_STATUS, 8'h01);
            settle(3);
            chk_bit(irq_out, 1'h0);
        end
        stop_try(STOP_SHALLOW, 1'h1);
        chk_bit(stop_mode_out === STOP_SHALLOW, 1'h1);
        chk_bit(detector_on_out, 1'h1);
        wake_up();
        chk_bit(in_stop_out, 1'h0);
        reg_write(ADDR_PMC_ONE, 8'h01);
        stop_try(STOP_DEEPEST, 1'h1);
        chk_bit(stop_mode_out === STOP_DEEPEST, 1'h1);
        chk_bit(detector_on_out, 1'h0);
        wake_up();
        chk_bit(detector_on_out, 1'h1);
        reg_check(ADDR_EVT_STATUS, 8'h02);
        report_and_stop();
    end
endmodule // testbench
